// ==== hw/timer_irq_flags.sv ====
// timer event flags, interrupt masks, prescaled counter and periodic tick over AHB-Lite
`timescale 1ns/1ps
module timer_irq_flags #(
  parameter int TICK_SHIFT = timer_irq_pkg::TICK_SHIFT_DEF
) (
  input wire logic clk_sys, // system clock, also the count clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic [3:0] match_evt, // compare 1..4 match pulses, bit 3 is channel 1
  input wire logic compare_five_evt, // compare five match pulse
  input wire logic capture_four_evt, // capture four edge pulse
  input wire logic [2:0] capture_evt, // capture 1..3 edge pulses, bit 2 is channel 1
  input wire logic accum_wrap_evt, // accumulator rolled to zero
  input wire logic accum_edge_evt, // selected edge on accumulator input pin
  input wire logic special_mode, // high lifts the prescale write-once limit
  output logic [15:0] free_running_count, // prescaled counter
  output logic count_step, // pulse: counter advances this cycle
  output logic [7:0] accum_control, // control byte for accumulator and select
  output logic [7:0] cc_irq, // capture/compare requests, register layout
  output logic [3:0] ot_irq // overflow, tick, wrap, edge requests
);
  logic [7:0] mask1_q;
  logic [7:0] flag1_q;
  logic [3:0] mask2_q;
  logic [3:0] flag2_q;
  logic [1:0] prescale_q;
  logic [3:0] pre_cnt_q;
  logic [3:0] pre_lim;
  logic [6:0] win_cnt_q;
  timer_irq_pkg::pr_state_e pr_state_q;
  logic pr_ok;
  logic dp_wr_q;
  logic [31:0] dp_addr_q;
  logic ap_take;
  logic [31:0] rd_mux;
  logic wr_mask1;
  logic wr_flag1;
  logic wr_mask2;
  logic wr_flag2;
  logic wr_ctl;
  logic [7:0] set1;
  logic [3:0] set2;
  logic fifth_set;
  logic ovf_set;
  logic tick_pulse;

  // address phase accepted on a selected nonseq with bus ready
  assign ap_take = hsel && hready && (htrans == timer_irq_pkg::HTRANS_NONSEQ);

  // data phase strobes, one per writable register
  assign wr_mask1 = dp_wr_q && (dp_addr_q == timer_irq_pkg::CC_MASK_ADDR);
  assign wr_flag1 = dp_wr_q && (dp_addr_q == timer_irq_pkg::CC_FLAG_ADDR);
  assign wr_mask2 = dp_wr_q && (dp_addr_q == timer_irq_pkg::OT_MASK_ADDR);
  assign wr_flag2 = dp_wr_q && (dp_addr_q == timer_irq_pkg::OT_FLAG_ADDR);
  assign wr_ctl = dp_wr_q && (dp_addr_q == timer_irq_pkg::ACC_CTL_ADDR);

  // read mux; unused bits and unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      timer_irq_pkg::CC_MASK_ADDR: rd_mux[7:0] = mask1_q;
      timer_irq_pkg::CC_FLAG_ADDR: rd_mux[7:0] = flag1_q;
      timer_irq_pkg::OT_MASK_ADDR: rd_mux[7:0] = {mask2_q, 2'b00, prescale_q};
      timer_irq_pkg::OT_FLAG_ADDR: rd_mux[7:0] = {flag2_q, 4'h0};
      timer_irq_pkg::ACC_CTL_ADDR: rd_mux[7:0] = accum_control;
      timer_irq_pkg::COUNT_ADDR: rd_mux[15:0] = free_running_count;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus slave: zero wait states, read data loaded at the address phase
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= timer_irq_pkg::HRESP_OKAY;
    end else begin
      dp_wr_q <= ap_take && hwrite;
      if (ap_take) begin
        dp_addr_q <= haddr;
      end
      if (ap_take && !hwrite) begin
        hrdata <= rd_mux;
      end
      hreadyout <= 1'b1;
      hresp <= timer_irq_pkg::HRESP_OKAY;
    end
  end

  // mask registers and control byte
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mask1_q <= timer_irq_pkg::CC_MASK_RST;
      mask2_q <= timer_irq_pkg::OT_MASK_RST;
      accum_control <= timer_irq_pkg::ACC_CTL_RST;
    end else begin
      if (wr_mask1) begin
        mask1_q <= hwdata[7:0];
      end
      if (wr_mask2) begin
        mask2_q <= hwdata[7:timer_irq_pkg::OT_LO];
      end
      if (wr_ctl) begin
        accum_control <= hwdata[7:0];
      end
    end
  end

  // prescale write window: open for a fixed count after reset
  assign pr_ok = special_mode ||
    ((pr_state_q == timer_irq_pkg::PR_OPEN) && (win_cnt_q < timer_irq_pkg::PR_WINDOW_CYCLES));

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      win_cnt_q <= 7'h00;
    end else if (win_cnt_q < timer_irq_pkg::PR_WINDOW_CYCLES) begin
      win_cnt_q <= win_cnt_q + 7'h01;
    end
  end

  // write-once lock; special mode accepts writes without locking
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pr_state_q <= timer_irq_pkg::PR_OPEN;
      prescale_q <= timer_irq_pkg::PRESCALE_RST;
    end else begin
      if (wr_mask2 && pr_ok) begin
        prescale_q <= hwdata[1:0];
      end
      case (pr_state_q)
        timer_irq_pkg::PR_OPEN: begin
          if (!special_mode && (wr_mask2 || win_cnt_q >= timer_irq_pkg::PR_WINDOW_CYCLES)) begin
            pr_state_q <= timer_irq_pkg::PR_LOCKED;
          end
        end
        timer_irq_pkg::PR_LOCKED: begin
          pr_state_q <= timer_irq_pkg::PR_LOCKED;
        end
        default: begin
          pr_state_q <= timer_irq_pkg::PR_LOCKED;
        end
      endcase
    end
  end

  // prescale limit lookup
  always_comb begin
    case (prescale_q)
      timer_irq_pkg::PRE_DIV1: pre_lim = timer_irq_pkg::PRE_LIM1;
      timer_irq_pkg::PRE_DIV4: pre_lim = timer_irq_pkg::PRE_LIM4;
      timer_irq_pkg::PRE_DIV8: pre_lim = timer_irq_pkg::PRE_LIM8;
      timer_irq_pkg::PRE_DIV16: pre_lim = timer_irq_pkg::PRE_LIM16;
      default: pre_lim = timer_irq_pkg::PRE_LIM1;
    endcase
  end

  // prescaler: one count_step pulse per divided period
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pre_cnt_q <= 4'h0;
      count_step <= 1'b0;
    end else if (pre_cnt_q >= pre_lim) begin
      pre_cnt_q <= 4'h0;
      count_step <= 1'b1;
    end else begin
      pre_cnt_q <= pre_cnt_q + 4'h1;
      count_step <= 1'b0;
    end
  end

  // free-running counter advances on the prescaled enable
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      free_running_count <= timer_irq_pkg::COUNT_RST;
    end else if (count_step) begin
      free_running_count <= free_running_count + 16'h0001;
    end
  end

  // periodic tick, independent of the prescaler
  tick_divider #(
    .TICK_SHIFT(TICK_SHIFT)
  ) u_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick_rate_select(accum_control[1:0]),
    .tick_pulse(tick_pulse)
  );

  // event sources in register bit order
  assign fifth_set = accum_control[timer_irq_pkg::SEL_BIT] ? capture_four_evt : compare_five_evt;
  assign set1 = {match_evt, fifth_set, capture_evt};
  assign ovf_set = count_step && (free_running_count == timer_irq_pkg::COUNT_MAX);
  assign set2 = {ovf_set, tick_pulse, accum_wrap_evt, accum_edge_evt};

  // flags: a set in the same cycle as a clear wins
  generate
    for (genvar i = 0; i < 8; i++) begin : g_flag1
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          flag1_q[i] <= timer_irq_pkg::CC_FLAG_RST[i];
        end else begin
          flag1_q[i] <= (flag1_q[i] && !(wr_flag1 && hwdata[i])) || set1[i];
        end
      end
    end
    for (genvar j = 0; j < 4; j++) begin : g_flag2
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          flag2_q[j] <= timer_irq_pkg::OT_FLAG_RST[j];
        end else begin
          flag2_q[j] <= (flag2_q[j] && !(wr_flag2 && hwdata[j + timer_irq_pkg::OT_LO])) || set2[j];
        end
      end
    end
  endgenerate

  // requests: registered and of flag with its enable, enables never touch flags
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cc_irq <= 8'h00;
      ot_irq <= 4'h0;
    end else begin
      cc_irq <= flag1_q & mask1_q;
      ot_irq <= flag2_q & mask2_q;
    end
  end

  compare_irq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (flag1_q[7] && mask1_q[7]) |=> cc_irq[7]) else $error("compare request missing");

  capture_irq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (flag1_q[2] && mask1_q[2]) |=> cc_irq[2]) else $error("capture request missing");

  fifth_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (accum_control[timer_irq_pkg::SEL_BIT] && capture_four_evt) |=> flag1_q[timer_irq_pkg::FIFTH_BIT])
    else $error("capture four did not set fifth flag");

  fifth_ignore_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (accum_control[timer_irq_pkg::SEL_BIT] && compare_five_evt && !capture_four_evt
     && !flag1_q[timer_irq_pkg::FIFTH_BIT]) |=> !flag1_q[timer_irq_pkg::FIFTH_BIT])
    else $error("compare five set flag while capture selected");

  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr_flag1 && hwdata[4] && !set1[4]) |=> !flag1_q[4]) else $error("write one did not clear flag");

  overflow_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (count_step && free_running_count == timer_irq_pkg::COUNT_MAX)
    |=> (flag2_q[timer_irq_pkg::OVF_IDX] && free_running_count == timer_irq_pkg::COUNT_RST))
    else $error("rollover did not set overflow flag");

  overflow_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !mask2_q[timer_irq_pkg::OVF_IDX] |=> !ot_irq[timer_irq_pkg::OVF_IDX])
    else $error("overflow request while disabled");

  prescale_lock_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr_mask2 && !special_mode && pr_state_q == timer_irq_pkg::PR_LOCKED) |=> $stable(prescale_q))
    else $error("prescale changed after lock");

  prescale_div_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (count_step && prescale_q == timer_irq_pkg::PRE_DIV16)
    |=> (!count_step || prescale_q != timer_irq_pkg::PRE_DIV16) [*8]) else $error("divide by sixteen stepped early");

  prescale_four_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (count_step && prescale_q == timer_irq_pkg::PRE_DIV4)
    |=> (!count_step || prescale_q != timer_irq_pkg::PRE_DIV4) [*3]) else $error("divide by four stepped early");

  match_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    match_evt[3] |=> flag1_q[7]) else $error("compare match did not set flag");

  capture_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    capture_evt[2] |=> flag1_q[2]) else $error("capture edge did not set flag");

  fifth_compare_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!accum_control[timer_irq_pkg::SEL_BIT] && compare_five_evt) |=> flag1_q[timer_irq_pkg::FIFTH_BIT])
    else $error("compare five did not set fifth flag");

  fifth_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (flag1_q[timer_irq_pkg::FIFTH_BIT] && mask1_q[timer_irq_pkg::FIFTH_BIT]) |=> cc_irq[timer_irq_pkg::FIFTH_BIT])
    else $error("fifth channel request missing");

  overflow_irq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (flag2_q[timer_irq_pkg::OVF_IDX] && mask2_q[timer_irq_pkg::OVF_IDX]) |=> ot_irq[timer_irq_pkg::OVF_IDX])
    else $error("overflow request missing");

  tick_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr_flag2 && hwdata[timer_irq_pkg::OT_LO + timer_irq_pkg::TICK_IDX] && !tick_pulse)
    |=> !flag2_q[timer_irq_pkg::TICK_IDX]) else $error("write one did not clear tick flag");

  wrap_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    accum_wrap_evt |=> flag2_q[timer_irq_pkg::WRAP_IDX]) else $error("accumulator wrap did not set flag");

  accum_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr_mask2 && !accum_edge_evt) |=> $stable(flag2_q[timer_irq_pkg::EDGE_IDX]))
    else $error("enable write changed accumulator edge flag");

  tick_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    tick_pulse |=> flag2_q[timer_irq_pkg::TICK_IDX]) else $error("tick did not set flag");

  tick_irq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (flag2_q[timer_irq_pkg::TICK_IDX] && mask2_q[timer_irq_pkg::TICK_IDX]) |=> ot_irq[timer_irq_pkg::TICK_IDX])
    else $error("tick request missing");

  overflow_seen_c: cover property (@(posedge clk_sys) disable iff (!resetn) ovf_set);
  prescale_write_c: cover property (@(posedge clk_sys) disable iff (!resetn) wr_mask2 && pr_ok);
  tick_irq_c: cover property (@(posedge clk_sys) disable iff (!resetn) ot_irq[timer_irq_pkg::TICK_IDX]);
endmodule // timer_irq_flags

// ==== hw/timer_irq_pkg.sv ====
// constants for the timer flag, mask, prescaler and periodic tick block
package timer_irq_pkg;
  // register byte addresses on the bus
  localparam logic [31:0] CC_MASK_ADDR = 32'h0000_0000;
  localparam logic [31:0] CC_FLAG_ADDR = 32'h0000_0004;
  localparam logic [31:0] OT_MASK_ADDR = 32'h0000_0008;
  localparam logic [31:0] OT_FLAG_ADDR = 32'h0000_000c;
  localparam logic [31:0] ACC_CTL_ADDR = 32'h0000_0010;
  localparam logic [31:0] COUNT_ADDR = 32'h0000_0014;
  // reset values
  localparam logic [7:0] CC_MASK_RST = 8'h00;
  localparam logic [7:0] CC_FLAG_RST = 8'h00;
  localparam logic [3:0] OT_MASK_RST = 4'h0;
  localparam logic [3:0] OT_FLAG_RST = 4'h0;
  localparam logic [7:0] ACC_CTL_RST = 8'h00;
  localparam logic [1:0] PRESCALE_RST = 2'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  // field positions
  localparam int FIFTH_BIT = 3;     // fifth channel in first flag/mask byte
  localparam int OT_LO = 4;         // flags of second byte sit in bits 7:4
  localparam int OVF_IDX = 3;       // overflow within the 4-bit high nibble
  localparam int TICK_IDX = 2;      // tick within the nibble (byte bit 6)
  localparam int WRAP_IDX = 1;      // accumulator wrap (byte bit 5)
  localparam int EDGE_IDX = 0;      // accumulator edge (byte bit 4)
  localparam int SEL_BIT = 2;       // fifth channel select in control byte
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // prescaler limits: divide by 1, 4, 8, 16
  typedef enum logic [1:0] {
    PRE_DIV1 = 2'b00,
    PRE_DIV4 = 2'b01,
    PRE_DIV8 = 2'b10,
    PRE_DIV16 = 2'b11
  } prescale_e;
  localparam logic [3:0] PRE_LIM1 = 4'h0;
  localparam logic [3:0] PRE_LIM4 = 4'h3;
  localparam logic [3:0] PRE_LIM8 = 4'h7;
  localparam logic [3:0] PRE_LIM16 = 4'hf;
  // write-once window for the prescale field, in clock cycles
  localparam logic [6:0] PR_WINDOW_CYCLES = 7'h40;
  typedef enum logic [0:0] {
    PR_OPEN = 1'b0,
    PR_LOCKED = 1'b1
  } pr_state_e;
  // tick base divider: two to this power clock cycles
  localparam int TICK_SHIFT_DEF = 13;
  localparam int TICK_RATE_STEPS = 3;
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

// ==== hw/tick_divider.sv ====
// free-running periodic tick divider with selectable rate
`timescale 1ns/1ps
module tick_divider #(
  parameter int TICK_SHIFT = timer_irq_pkg::TICK_SHIFT_DEF
) (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [1:0] tick_rate_select, // extra division 1, 2, 4, 8
  output logic tick_pulse // one-cycle timeout pulse
);
  localparam int W = TICK_SHIFT + timer_irq_pkg::TICK_RATE_STEPS;

  logic [W-1:0] div_q;
  logic [W-1:0] lim;
  logic hit;

  // low TICK_SHIFT+rate bits all ones ends a period
  assign lim = {W{1'b1}} >> (2'(timer_irq_pkg::TICK_RATE_STEPS) - tick_rate_select);
  assign hit = (div_q & lim) == lim;

  // divider runs freely; only reset stops or restarts it
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // timeout pulse registered from the divider
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tick_pulse <= 1'b0;
    end else begin
      tick_pulse <= hit;
    end
  end

  tick_single_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    tick_pulse |=> !tick_pulse) else $error("tick pulse longer than one cycle");

  tick_seen_c: cover property (@(posedge clk_sys) disable iff (!resetn) tick_pulse);
endmodule // tick_divider

// ==== verification/timer_irq_flags_tb_top.sv ====
// self-checking bench for the timer flags, masks, prescaler and periodic tick block
`timescale 1ns/1ps
module timer_irq_flags_tb_top;
  localparam int TSHIFT = 3; // short tick base so every rate fits in the run
  localparam int CEILING = 90000; // overflow run plus margin
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [3:0] match_evt = 4'h0;
  logic compare_five_evt = 1'b0;
  logic capture_four_evt = 1'b0;
  logic [2:0] capture_evt = 3'h0;
  logic accum_wrap_evt = 1'b0;
  logic accum_edge_evt = 1'b0;
  logic special_mode = 1'b0;
  logic [15:0] free_running_count;
  logic count_step;
  logic [7:0] accum_control;
  logic [7:0] cc_irq;
  logic [3:0] ot_irq;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  // single slave: its ready output is the bus ready
  timer_irq_flags #(.TICK_SHIFT(TSHIFT)) i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .match_evt(match_evt), .compare_five_evt(compare_five_evt), .capture_four_evt(capture_four_evt),
    .capture_evt(capture_evt), .accum_wrap_evt(accum_wrap_evt), .accum_edge_evt(accum_edge_evt),
    .special_mode(special_mode), .free_running_count(free_running_count), .count_step(count_step),
    .accum_control(accum_control), .cc_irq(cc_irq), .ot_irq(ot_irq)
  );

  task automatic end_sim;
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // cycle counter, also cuts a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc >= CEILING) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single-word transfer; address phase held until ready, then data phase
  task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= addr;
    hwrite <= wr;
    htrans <= timer_irq_pkg::HTRANS_NONSEQ;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= data;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask

  task automatic bus_wr(input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] dummy;
    bus_xfer(1'b1, addr, data, dummy);
  endtask

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp, input logic [31:0] ign);
    logic [31:0] d;
    bus_xfer(1'b0, addr, 32'h0000_0000, d);
    chk(d & ~ign, exp);
  endtask

  // one-cycle event pulses, then let flag and request settle
  task automatic pulse(input logic [3:0] m, input logic [2:0] c, input logic c5, input logic c4, input logic w,
                       input logic e);
    @(posedge clk_sys);
    match_evt <= m;
    capture_evt <= c;
    compare_five_evt <= c5;
    capture_four_evt <= c4;
    accum_wrap_evt <= w;
    accum_edge_evt <= e;
    @(posedge clk_sys);
    match_evt <= 4'h0;
    capture_evt <= 3'h0;
    compare_five_evt <= 1'b0;
    capture_four_evt <= 1'b0;
    accum_wrap_evt <= 1'b0;
    accum_edge_evt <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask

  // cycles between two counter advances
  task automatic step_gap(input int exp);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (count_step !== 1'b1) @(posedge clk_sys);
    do begin
      @(posedge clk_sys);
      n++;
    end while (count_step !== 1'b1);
    chk(n, exp);
  endtask

  // cycles between two tick requests, with a flag clear in between
  task automatic tick_gap(input int exp);
    int t0;
    bus_wr(timer_irq_pkg::OT_FLAG_ADDR, 32'h40);
    repeat (2) @(posedge clk_sys);
    while (ot_irq[2] !== 1'b1) @(posedge clk_sys);
    t0 = cyc;
    bus_wr(timer_irq_pkg::OT_FLAG_ADDR, 32'h40);
    repeat (2) @(posedge clk_sys);
    while (ot_irq[2] !== 1'b1) @(posedge clk_sys);
    chk(cyc - t0, exp);
  endtask

  // prescale written inside the window, later write ignored, reset values
  task automatic t_prescale_regs;
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'h01);
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'h03);
    rd_chk(timer_irq_pkg::OT_MASK_ADDR, 32'h01, 32'h0);
    step_gap(4);
    rd_chk(timer_irq_pkg::CC_MASK_ADDR, 32'h00, 32'h0);
    rd_chk(timer_irq_pkg::CC_FLAG_ADDR, 32'h00, 32'h0);
    rd_chk(timer_irq_pkg::ACC_CTL_ADDR, 32'h00, 32'h0);
    rd_chk(32'h0000_0018, 32'h00, 32'h0);
    chk(hresp, 1'b0);
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'hff);
    rd_chk(timer_irq_pkg::OT_MASK_ADDR, 32'hf1, 32'h0);
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'h00);
  endtask

  // compare and capture flags, masks, write-one clear, fifth channel select
  task automatic t_capture_compare;
    pulse(4'b1001, 3'b010, 1'b0, 1'b0, 1'b0, 1'b0);
    rd_chk(timer_irq_pkg::CC_FLAG_ADDR, 32'h92, 32'h0);
    pulse(4'b0110, 3'b101, 1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk(timer_irq_pkg::CC_FLAG_ADDR, 32'hff, 32'h0);
    chk(cc_irq, 8'h00);
    bus_wr(timer_irq_pkg::CC_MASK_ADDR, 32'ha5);
    repeat (2) @(posedge clk_sys);
    chk(cc_irq, 8'ha5);
    bus_wr(timer_irq_pkg::CC_FLAG_ADDR, 32'h0f);
    rd_chk(timer_irq_pkg::CC_FLAG_ADDR, 32'hf0, 32'h0);
    bus_wr(timer_irq_pkg::CC_FLAG_ADDR, 32'h00);
    rd_chk(timer_irq_pkg::CC_FLAG_ADDR, 32'hf0, 32'h0);
    chk(cc_irq, 8'ha0);
    bus_wr(timer_irq_pkg::CC_FLAG_ADDR, 32'hff);
    bus_wr(timer_irq_pkg::CC_MASK_ADDR, 32'h08);
    pulse(4'h0, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    rd_chk(timer_irq_pkg::CC_FLAG_ADDR, 32'h00, 32'h0);
    bus_wr(timer_irq_pkg::ACC_CTL_ADDR, 32'h04);
    rd_chk(timer_irq_pkg::ACC_CTL_ADDR, 32'h04, 32'h0);
    chk(accum_control, 8'h04);
    pulse(4'h0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk(timer_irq_pkg::CC_FLAG_ADDR, 32'h00, 32'h0);
    pulse(4'h0, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    rd_chk(timer_irq_pkg::CC_FLAG_ADDR, 32'h08, 32'h0);
    chk(cc_irq, 8'h08);
    bus_wr(timer_irq_pkg::CC_FLAG_ADDR, 32'h08);
    bus_wr(timer_irq_pkg::ACC_CTL_ADDR, 32'h00);
  endtask

  // accumulator flags and their enables; tick flag masked out of reads
  task automatic t_accum;
    pulse(4'h0, 3'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    rd_chk(timer_irq_pkg::OT_FLAG_ADDR, 32'h30, 32'h40);
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'h10);
    repeat (2) @(posedge clk_sys);
    chk(ot_irq, 4'h1);
    bus_wr(timer_irq_pkg::OT_FLAG_ADDR, 32'h20);
    rd_chk(timer_irq_pkg::OT_FLAG_ADDR, 32'h10, 32'h40);
    bus_wr(timer_irq_pkg::OT_FLAG_ADDR, 32'h10);
    rd_chk(timer_irq_pkg::OT_FLAG_ADDR, 32'h00, 32'h40);
  endtask

  // tick spacing for every rate code, then masked tick
  task automatic t_tick;
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'h40);
    for (int r = 0; r < 4; r++) begin
      bus_wr(timer_irq_pkg::ACC_CTL_ADDR, r);
      tick_gap(1 << (TSHIFT + r));
    end
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'h00);
    bus_wr(timer_irq_pkg::OT_FLAG_ADDR, 32'h40);
    repeat (70) @(posedge clk_sys);
    chk(ot_irq, 4'h0);
    rd_chk(timer_irq_pkg::OT_FLAG_ADDR, 32'h40, 32'h0);
    bus_wr(timer_irq_pkg::ACC_CTL_ADDR, 32'h00);
  endtask

  // second reset: first tick, closed window, overflow, special mode
  task automatic t_overflow;
    do_reset();
    rd_chk(timer_irq_pkg::OT_FLAG_ADDR, 32'h00, 32'h0);
    repeat (8) @(posedge clk_sys);
    rd_chk(timer_irq_pkg::OT_FLAG_ADDR, 32'h40, 32'h0);
    repeat (70) @(posedge clk_sys);
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'h8f);
    rd_chk(timer_irq_pkg::OT_MASK_ADDR, 32'h80, 32'h0);
    step_gap(1);
    while (!(free_running_count === 16'hffff && count_step === 1'b1)) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    chk(ot_irq, 4'h8);
    chk(free_running_count, 16'h0002);
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'h00);
    repeat (2) @(posedge clk_sys);
    chk(ot_irq, 4'h0);
    rd_chk(timer_irq_pkg::OT_FLAG_ADDR, 32'hc0, 32'h0);
    bus_wr(timer_irq_pkg::OT_FLAG_ADDR, 32'h80);
    rd_chk(timer_irq_pkg::OT_FLAG_ADDR, 32'h40, 32'h0);
    @(posedge clk_sys);
    special_mode <= 1'b1;
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'h02);
    rd_chk(timer_irq_pkg::OT_MASK_ADDR, 32'h02, 32'h0);
    step_gap(8);
    bus_wr(timer_irq_pkg::OT_MASK_ADDR, 32'h03);
    step_gap(16);
  endtask

  // main sequence
  initial begin
    do_reset();
    t_prescale_regs();
    t_capture_compare();
    t_accum();
    t_tick();
    t_overflow();
    end_sim();
  end
endmodule // timer_irq_flags_tb_top
